// ### dio_defs.svh
// register offsets, field positions, reset values and timing counts
`ifndef DIO_DEFS_SVH
`define DIO_DEFS_SVH

// ****************
// register offsets
// ****************
`define DIO_OFF_DIN     8'h00
`define DIO_OFF_DOUT    8'h04
`define DIO_OFF_ORMASK  8'h08
`define DIO_OFF_ANDMASK 8'h0c
`define DIO_OFF_WDLOAD  8'h10
`define DIO_OFF_WDCTRL  8'h14
`define DIO_OFF_WDKICK  8'h18
`define DIO_OFF_TM0     8'h1c
`define DIO_OFF_TM1     8'h20
`define DIO_OFF_TM2     8'h24
`define DIO_OFF_TMCTRL  8'h28
`define DIO_OFF_STATUS  8'h2c
`define DIO_OFF_MASK    8'h30
`define DIO_OFF_DIAG    8'h34
`define DIO_OFF_ROUTE   8'h38

// ****************
// status bits
// ****************
`define DIO_ST_OR     0
`define DIO_ST_AND    1
`define DIO_ST_WD     2
`define DIO_ST_TM0    3
`define DIO_ST_FUSE   6
`define DIO_ST_SUPPLY 7
`define DIO_ST_SHORT  8
`define DIO_ST_OVT    9

// ****************
// field positions
// ****************
`define DIO_WD_EN    0
`define DIO_WD_TRIP  1
`define DIO_SY_FUSE  16
`define DIO_SY_SUP   17
`define DIO_SY_SHORT 18
`define DIO_SY_OVT   19

// ****************
// reset values
// ****************
`define DIO_RST_WAIT 1'b1
`define DIO_RST_ZERO 32'h0000_0000

// ****************
// timing
// ****************
`define DIO_CLK_NS    10
`define DIO_TICK_US   10
`define DIO_WD_MAX_US 37000000
`define DIO_NS_PER_US 1000

`endif

// ### dio_pkg.sv
// types shared by the digital i/o controller files
package dio_pkg;

   // ****************
   // widths
   // ****************
   localparam int DIO_NCH = 16;
   localparam int DIO_NIRQ = 14;
   localparam int DIO_TW = 22;
   localparam int DIO_NSYNC = 20;
   localparam int DIO_NST = 10;
   localparam int DIO_PW = 10;

   typedef enum logic {
      DIO_BUS_IDLE,
      DIO_BUS_ACK
   } dio_bus_t;

   typedef logic [DIO_TW-1:0] dio_cnt_t;

   typedef struct packed {
      dio_cnt_t count;
      logic     expired;
   } dio_tim_t;

   typedef struct packed {
      dio_bus_t                busSt;
      logic                    waitReq;
      logic [31:0]             rdData;
      logic [DIO_NCH-1:0]      dOutCmd;
      logic [DIO_NCH-1:0]      dOutPin;
      logic [DIO_NIRQ-1:0]     orMask;
      logic [DIO_NIRQ-1:0]     andMask;
      logic                    andHit;
      dio_cnt_t                wdLoad;
      logic                    wdEn;
      logic                    wdTrip;
      logic                    wdKick;
      logic [2:0][DIO_TW-1:0]  tmLoad;
      logic [2:0]              tmEn;
      logic [2:0]              tmKick;
      logic [DIO_NST-1:0]      status;
      logic [DIO_NST-1:0]      mask;
      logic [1:0]              route;
      logic                    irq;
      logic [DIO_NSYNC-1:0]    syncA;
      logic [DIO_NSYNC-1:0]    syncB;
      logic [DIO_NCH-1:0]      prevIn;
      logic [DIO_PW-1:0]       preCnt;
      logic                    tick;
   } dio_st_t;

endpackage

// ### dio_timer.sv
// reloading down-counter in 10 us ticks, used for watchdog and timers
`timescale 1ns/1ps

module dio_timer
   import dio_pkg::*;
(
   input  wire logic     clock,
   input  wire logic     rst_b,
   input  wire logic     tick,
   input  wire logic     enable,
   input  wire logic     restart,
   input  wire dio_cnt_t load,
   output dio_cnt_t      count,
   output logic          expired
);

   dio_tim_t st_reg;
   dio_tim_t st_next;

   // ****************
   // count down
   // ****************
   always_comb begin
      st_next = st_reg;
      st_next.expired = 1'b0;
      if (restart || !enable) begin
         st_next.count = load;
      end else if (tick) begin
         if (st_reg.count <= dio_cnt_t'(1)) begin
            st_next.expired = 1'b1;
            st_next.count = load;
         end else begin
            st_next.count = st_reg.count - dio_cnt_t'(1);
         end
      end
   end

   always_ff @(posedge clock or negedge rst_b) begin
      if (!rst_b) begin
         st_reg <= '0;
      end else begin
         st_reg <= st_next;
      end
   end

   assign count = st_reg.count;
   assign expired = st_reg.expired;

endmodule // dio_timer

// ### dio_top.sv
// digital i/o controller with compare logic, watchdog and timers
`timescale 1ns/1ps
`include "dio_defs.svh"

// Contract
// R1: sixteen inputs and sixteen outputs each readable or writable by bit.
// R2: all outputs are zero after reset until software writes them.
// R3: only inputs 0 to 13 raise events, the interrupt line is software set.
// R4: an enabled input change always raises an interrupt event.
// R5: compare logic has an and mode and an or mode, or wins when both hit.
// R6: watchdog expiry forces all outputs to zero and raises an interrupt.
// R7: watchdog timeout is set from 10 us to 37 s in 10 us steps.
// R8: three software timers each raise an interrupt event.
// R9: short, overtemperature, supply drop and watchdog show as status bits.
// R10: a fuse trip switches all outputs off while it lasts.
// R11: an external supply below 5 V forces all outputs off.
// R12: outputs return to the commanded value once a trip clears.
// R13: all settings and values are reached through bus registers.
// R14: forcing leaves the commanded value intact, each cause has a flag.
module dio_top
   import dio_pkg::*;
#(
   parameter int WD_MAX_TICKS = `DIO_WD_MAX_US / `DIO_TICK_US
)
(
   input  wire logic        clock,
   input  wire logic        rst_b,
   input  wire logic [7:0]  avsAddress,
   input  wire logic        avsRead,
   input  wire logic        avsWrite,
   input  wire logic [31:0] avsWriteData,
   input  wire logic [3:0]  avsByteEnable,
   output logic [31:0]      avsReadData,
   output logic             avsWaitRequest,
   input  wire logic [15:0] fieldIn,
   input  wire logic        fuseTrip,
   input  wire logic        supplyLow,
   input  wire logic        shortFault,
   input  wire logic        overTemp,
   output logic [15:0]      fieldOut,
   output logic             irq,
   output logic [1:0]       irqRoute
);

   // ****************
   // constants
   // ****************
   localparam int TICK_CYC = `DIO_TICK_US * `DIO_NS_PER_US / `DIO_CLK_NS;
   localparam dio_cnt_t WD_MAX = dio_cnt_t'(WD_MAX_TICKS);

   dio_st_t st_reg;
   dio_st_t st_next;
   logic [3:0]       timExp;
   dio_cnt_t         wdCount;
   logic [3:0]       timRestart;
   logic [3:0]       timEnable;
   logic [3:0][21:0] timLoad;

   // ****************
   // helpers
   // ****************
   function automatic logic hit(input logic [7:0] a, input logic [7:0] off);
      hit = (a[7:2] == off[7:2]);
   endfunction

   function automatic logic [31:0] merge(input logic [31:0] old,
                                         input logic [31:0] wd,
                                         input logic [3:0]  be);
      merge = old;
      for (int i = 0; i < 4; i++) begin
         if (be[i]) begin
            merge[i*8 +: 8] = wd[i*8 +: 8];
         end
      end
   endfunction

   function automatic dio_cnt_t clampLoad(input logic [31:0] v);
      clampLoad = v[DIO_TW-1:0];
      if (v > 32'(WD_MAX_TICKS)) begin
         clampLoad = WD_MAX;
      end else if (clampLoad == '0) begin
         clampLoad = dio_cnt_t'(1);
      end
   endfunction

   // ****************
   // watchdog and timers
   // ****************
   assign timLoad[0] = st_reg.wdLoad;
   assign timEnable[0] = st_reg.wdEn;
   assign timRestart[0] = st_reg.wdKick;

   generate
      for (genvar g = 1; g < 4; g++) begin : gTim
         assign timLoad[g] = st_reg.tmLoad[g-1];
         assign timEnable[g] = st_reg.tmEn[g-1];
         assign timRestart[g] = st_reg.tmKick[g-1];
      end
      for (genvar g = 0; g < 4; g++) begin : gInst
         dio_cnt_t cnt;
         dio_timer uTim (
            .clock   (clock),
            .rst_b   (rst_b),
            .tick    (st_reg.tick),
            .enable  (timEnable[g]),
            .restart (timRestart[g]),
            .load    (timLoad[g]),
            .count   (cnt),
            .expired (timExp[g])
         );
         if (g == 0) begin : gWd
            assign wdCount = cnt;
         end
      end
   endgenerate

   // ****************
   // next state
   // ****************
   always_comb begin
      logic [31:0]          rd;
      logic [31:0]          wv;
      logic                 wr;
      logic [DIO_NCH-1:0]   din;
      logic [DIO_NIRQ-1:0]  chg;
      logic                 orHit;
      logic                 andNow;
      logic [31:0]          dv;
      logic [DIO_NST-1:0]   ev;
      logic [DIO_NST-1:0]   clr;
      logic                 force0;
      rd = '0;
      wv = '0;
      wr = 1'b0;
      din = '0;
      chg = '0;
      orHit = 1'b0;
      andNow = 1'b0;
      dv = '0;
      ev = '0;
      clr = '0;
      force0 = 1'b0;
      st_next = st_reg;

      // two-stage pin synchronisers
      st_next.syncA = {overTemp, shortFault, supplyLow, fuseTrip, fieldIn};
      st_next.syncB = st_reg.syncA;
      din = st_reg.syncB[DIO_NCH-1:0];
      st_next.prevIn = din;

      // 10 us tick prescaler
      st_next.tick = 1'b0;
      if (st_reg.preCnt == DIO_PW'(TICK_CYC - 1)) begin
         st_next.preCnt = '0;
         st_next.tick = 1'b1;
      end else begin
         st_next.preCnt = st_reg.preCnt + DIO_PW'(1);
      end

      // compare logic
      chg = din[DIO_NIRQ-1:0] ^ st_reg.prevIn[DIO_NIRQ-1:0]; // [R3]
      orHit = |(chg & st_reg.orMask); // [R4]
      andNow = (|st_reg.andMask) &&
               ((din[DIO_NIRQ-1:0] & st_reg.andMask) == st_reg.andMask);
      st_next.andHit = andNow;
      ev[`DIO_ST_OR] = orHit; // [R5]
      ev[`DIO_ST_AND] = andNow && !st_reg.andHit && !orHit; // [R5]
      ev[`DIO_ST_WD] = timExp[0]; // [R6] [R9]
      ev[`DIO_ST_TM0 +: 3] = timExp[3:1]; // [R8]
      ev[`DIO_ST_FUSE] = st_reg.syncB[`DIO_SY_FUSE]; // [R14]
      ev[`DIO_ST_SUPPLY] = st_reg.syncB[`DIO_SY_SUP]; // [R14]
      ev[`DIO_ST_SHORT] = st_reg.syncB[`DIO_SY_SHORT]; // [R9]
      ev[`DIO_ST_OVT] = st_reg.syncB[`DIO_SY_OVT]; // [R9]

      // register read mux
      unique case (avsAddress[7:2])
         `DIO_OFF_DIN >> 2:     rd[15:0] = din; // [R1]
         `DIO_OFF_DOUT >> 2:    rd[15:0] = st_reg.dOutCmd;
         `DIO_OFF_ORMASK >> 2:  rd[13:0] = st_reg.orMask;
         `DIO_OFF_ANDMASK >> 2: rd[13:0] = st_reg.andMask;
         `DIO_OFF_WDLOAD >> 2:  rd[21:0] = st_reg.wdLoad;
         `DIO_OFF_WDCTRL >> 2:  rd[1:0] = {st_reg.wdTrip, st_reg.wdEn};
         `DIO_OFF_WDKICK >> 2:  rd[21:0] = wdCount;
         `DIO_OFF_TM0 >> 2:     rd[21:0] = st_reg.tmLoad[0];
         `DIO_OFF_TM1 >> 2:     rd[21:0] = st_reg.tmLoad[1];
         `DIO_OFF_TM2 >> 2:     rd[21:0] = st_reg.tmLoad[2];
         `DIO_OFF_TMCTRL >> 2:  rd[2:0] = st_reg.tmEn;
         `DIO_OFF_STATUS >> 2:  rd[9:0] = st_reg.status;
         `DIO_OFF_MASK >> 2:    rd[9:0] = st_reg.mask;
         `DIO_OFF_DIAG >> 2:    rd[4:0] = {st_reg.wdTrip,
            st_reg.syncB[`DIO_SY_OVT:`DIO_SY_FUSE]};
         `DIO_OFF_ROUTE >> 2:   rd[1:0] = st_reg.route;
         default:               rd = `DIO_RST_ZERO;
      endcase

      // avalon slave handshake
      st_next.wdKick = 1'b0;
      st_next.tmKick = '0;
      unique case (st_reg.busSt)
         DIO_BUS_IDLE: begin
            if (avsRead || avsWrite) begin
               st_next.busSt = DIO_BUS_ACK;
               st_next.waitReq = 1'b0;
               st_next.rdData = rd;
            end
         end
         DIO_BUS_ACK: begin
            st_next.busSt = DIO_BUS_IDLE;
            st_next.waitReq = 1'b1;
            wr = avsWrite;
         end
      endcase

      // register writes [R13]
      wv = merge(`DIO_RST_ZERO, avsWriteData, avsByteEnable);
      dv = merge(32'(st_reg.dOutCmd), avsWriteData, avsByteEnable);
      if (wr) begin
         if (hit(avsAddress, `DIO_OFF_DOUT)) begin
            st_next.dOutCmd = dv[15:0]; // [R1]
         end
         if (hit(avsAddress, `DIO_OFF_ORMASK)) begin
            st_next.orMask = wv[13:0];
         end
         if (hit(avsAddress, `DIO_OFF_ANDMASK)) begin
            st_next.andMask = wv[13:0];
         end
         if (hit(avsAddress, `DIO_OFF_WDLOAD)) begin
            st_next.wdLoad = clampLoad(avsWriteData); // [R7]
            st_next.wdKick = 1'b1;
         end
         if (hit(avsAddress, `DIO_OFF_WDCTRL)) begin
            st_next.wdEn = avsWriteData[`DIO_WD_EN];
            st_next.wdKick = 1'b1;
         end
         if (hit(avsAddress, `DIO_OFF_WDKICK)) begin
            st_next.wdKick = 1'b1;
         end
         for (int i = 0; i < 3; i++) begin
            if (hit(avsAddress, 8'(`DIO_OFF_TM0 + 4 * i))) begin
               st_next.tmLoad[i] = clampLoad(avsWriteData); // [R8]
               st_next.tmKick[i] = 1'b1;
            end
         end
         if (hit(avsAddress, `DIO_OFF_TMCTRL)) begin
            st_next.tmEn = avsWriteData[2:0];
            st_next.tmKick = 3'b111;
         end
         if (hit(avsAddress, `DIO_OFF_STATUS)) begin
            clr = wv[9:0];
         end
         if (hit(avsAddress, `DIO_OFF_MASK)) begin
            st_next.mask = wv[9:0];
         end
         if (hit(avsAddress, `DIO_OFF_ROUTE)) begin
            st_next.route = wv[1:0]; // [R3]
         end
      end

      // sticky status, set wins over clear
      st_next.status = (st_reg.status & ~clr) | ev; // [R9]
      st_next.irq = |(st_next.status & st_next.mask); // [R4]

      // watchdog trip held until re-armed
      st_next.wdTrip = timExp[0] || (st_reg.wdTrip && !st_reg.wdKick); // [R6]

      // output forcing
      force0 = st_next.wdTrip ||
               st_reg.syncB[`DIO_SY_FUSE] || // [R10]
               st_reg.syncB[`DIO_SY_SUP]; // [R11]
      st_next.dOutPin = force0 ? '0 : st_next.dOutCmd; // [R12] [R14]
   end

   always_ff @(posedge clock or negedge rst_b) begin
      if (!rst_b) begin
         st_reg <= '0; // [R2]
         st_reg.waitReq <= `DIO_RST_WAIT;
         st_reg.wdLoad <= WD_MAX;
         st_reg.tmLoad <= {3{WD_MAX}};
      end else begin
         st_reg <= st_next;
      end
   end

   assign avsReadData = st_reg.rdData;
   assign avsWaitRequest = st_reg.waitReq;
   assign fieldOut = st_reg.dOutPin;
   assign irq = st_reg.irq;
   assign irqRoute = st_reg.route;

   // ****************
   // checks
   // ****************
   logic outWritten;
   always_ff @(posedge clock or negedge rst_b) begin
      if (!rst_b) begin
         outWritten <= 1'b0;
      end else if (st_reg.busSt == DIO_BUS_ACK && avsWrite &&
                   hit(avsAddress, `DIO_OFF_DOUT)) begin
         outWritten <= 1'b1;
      end
   end

   property p_reset_zero;
      @(posedge clock) disable iff (!rst_b)
         !outWritten |-> fieldOut == '0;
   endproperty
   a_reset_zero: assert property (p_reset_zero) // [R2]
      else $error("outputs not zero before first write");
   property p_wd_force;
      @(posedge clock) disable iff (!rst_b)
         timExp[0] |=> fieldOut == '0 && st_reg.status[`DIO_ST_WD];
   endproperty
   a_wd_force: assert property (p_wd_force) // [R6]
      else $error("watchdog expiry did not force outputs");
   property p_fuse_off;
      @(posedge clock) disable iff (!rst_b)
         st_reg.syncB[`DIO_SY_FUSE] |=> fieldOut == '0;
   endproperty
   a_fuse_off: assert property (p_fuse_off) // [R10]
      else $error("fuse trip left outputs on");
   property p_supply_off;
      @(posedge clock) disable iff (!rst_b)
         st_reg.syncB[`DIO_SY_SUP] |=> fieldOut == '0 ##0
         st_reg.status[`DIO_ST_SUPPLY];
   endproperty
   a_supply_off: assert property (p_supply_off) // [R11]
      else $error("supply loss left outputs on");
   property p_restore;
      @(posedge clock) disable iff (!rst_b)
         (!st_reg.wdTrip && !timExp[0] && !st_reg.syncB[`DIO_SY_FUSE] &&
          !st_reg.syncB[`DIO_SY_SUP]) |=>
         fieldOut == st_reg.dOutCmd;
   endproperty
   a_restore: assert property (p_restore) // [R12]
      else $error("outputs not restored to commanded value");
   property p_cmd_kept;
      @(posedge clock) disable iff (!rst_b)
         st_reg.busSt == DIO_BUS_IDLE |=> $stable(st_reg.dOutCmd);
   endproperty
   a_cmd_kept: assert property (p_cmd_kept) // [R14]
      else $error("commanded outputs changed without a write");
   property p_or_event;
      @(posedge clock) disable iff (!rst_b)
         |((st_reg.syncB[13:0] ^ st_reg.prevIn[13:0]) & st_reg.orMask)
         |=> st_reg.status[`DIO_ST_OR] ##1 irq || !st_reg.mask[0];
   endproperty
   a_or_event: assert property (p_or_event) // [R4]
      else $error("enabled input change raised no event");
   property p_or_prio;
      @(posedge clock) disable iff (!rst_b)
         (|((st_reg.syncB[13:0] ^ st_reg.prevIn[13:0]) & st_reg.orMask)
          && !st_reg.status[`DIO_ST_AND]) |=> !st_reg.status[`DIO_ST_AND];
   endproperty
   a_or_prio: assert property (p_or_prio) // [R5]
      else $error("and event set while or event had priority");
   property p_timer_irq;
      @(posedge clock) disable iff (!rst_b)
         |timExp[3:1] |=> |st_reg.status[`DIO_ST_TM0 +: 3];
   endproperty
   a_timer_irq: assert property (p_timer_irq) // [R8]
      else $error("timer expiry not flagged");
   property p_bus_ack;
      @(posedge clock) disable iff (!rst_b)
         (avsRead || avsWrite) && st_reg.busSt == DIO_BUS_IDLE |=>
         !avsWaitRequest ##1 avsWaitRequest;
   endproperty
   a_bus_ack: assert property (p_bus_ack) // [R13]
      else $error("bus answer not one cycle after request");

endmodule // dio_top

// ### dio_field_model.sv
// field side model: input channels and protection fault levels
`timescale 1ns/1ps

module dio_field_model (
   input  wire logic        clock,
   input  wire logic        rst_b,
   input  wire logic [15:0] inCmd,
   input  wire logic [3:0]  faultCmd,
   output logic [15:0]      fieldIn,
   output logic             fuseTrip,
   output logic             supplyLow,
   output logic             shortFault,
   output logic             overTemp
);
   // ****************
   // pin drivers
   // ****************
   always_ff @(posedge clock or negedge rst_b) begin
      if (!rst_b) begin
         fieldIn <= 16'h0000;
         fuseTrip <= 1'b0;
         supplyLow <= 1'b0;
         shortFault <= 1'b0;
         overTemp <= 1'b0;
      end else begin
         fieldIn <= inCmd;
         fuseTrip <= faultCmd[0];
         supplyLow <= faultCmd[1];
         shortFault <= faultCmd[2];
         overTemp <= faultCmd[3];
      end
   end
endmodule // dio_field_model

// ### tb_top.sv
// self-checking bench of the digital i/o controller
`timescale 1ns/1ps
`include "dio_defs.svh"

module tb_top;
   localparam int WDT = 50;
   logic        clock = 1'b0;
   logic        rst_b;
   logic [7:0]  avsAddress;
   logic        avsRead;
   logic        avsWrite;
   logic [31:0] avsWriteData;
   logic [3:0]  avsByteEnable;
   logic [31:0] avsReadData;
   logic        avsWaitRequest;
   logic [15:0] fieldIn;
   logic        fuseTrip;
   logic        supplyLow;
   logic        shortFault;
   logic        overTemp;
   logic [15:0] fieldOut;
   logic        irq;
   logic [1:0]  irqRoute;
   logic [15:0] inCmd;
   logic [3:0]  faultCmd;
   logic [31:0] q;
   logic [15:0] dout;
   int          error_cnt;
   int          n_tests;
   int          i;
   int          n;

   dio_top #(.WD_MAX_TICKS(WDT)) dio_top_i (
      .clock(clock), .rst_b(rst_b), .avsAddress(avsAddress),
      .avsRead(avsRead), .avsWrite(avsWrite),
      .avsWriteData(avsWriteData), .avsByteEnable(avsByteEnable),
      .avsReadData(avsReadData), .avsWaitRequest(avsWaitRequest),
      .fieldIn(fieldIn), .fuseTrip(fuseTrip), .supplyLow(supplyLow),
      .shortFault(shortFault), .overTemp(overTemp),
      .fieldOut(fieldOut), .irq(irq), .irqRoute(irqRoute));

   dio_field_model dio_field_model_i (
      .clock(clock), .rst_b(rst_b), .inCmd(inCmd),
      .faultCmd(faultCmd), .fieldIn(fieldIn), .fuseTrip(fuseTrip),
      .supplyLow(supplyLow), .shortFault(shortFault),
      .overTemp(overTemp));

   always #5 clock = ~clock;

   // ****************
   // tasks
   // ****************
   task automatic conclude();
      $display("comparisons %0d mismatches %0d", n_tests, error_cnt);
      if (error_cnt == 0 && n_tests > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_tests++;
      if (got !== exp) begin
         error_cnt++;
         $display("mismatch at %0t got %h exp %h", $time, got, exp);
      end
   endtask

   task automatic bus(input logic w, input logic [7:0] a,
                      input logic [31:0] d, input logic [3:0] be);
      int k;
      @(posedge clock);
      avsAddress <= a;
      avsWrite <= w;
      avsRead <= !w;
      avsWriteData <= d;
      avsByteEnable <= be;
      k = 0;
      do begin
         @(posedge clock);
         k++;
      end while (avsWaitRequest !== 1'b0 && k < 100);
      q = avsReadData;
      avsRead <= 1'b0;
      avsWrite <= 1'b0;
      if (k >= 100) begin
         error_cnt++;
         conclude();
      end
   endtask

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      bus(1'b1, a, d, 4'hf);
   endtask

   task automatic rdchk(input logic [7:0] a, input logic [31:0] e);
      bus(1'b0, a, 32'h0, 4'h0);
      chk(q, e);
   endtask

   task automatic idle(input int c);
      repeat (c) @(posedge clock);
   endtask

   task automatic setIn(input logic [15:0] v);
      @(posedge clock);
      inCmd <= v;
      idle(6);
   endtask

   // ****************
   // watchdog of the run
   // ****************
   initial begin
      #400000;
      error_cnt++;
      conclude();
   end

   // ****************
   // main sequence
   // ****************
   initial begin
      rst_b = 1'b0;
      avsAddress = 8'h00;
      avsRead = 1'b0;
      avsWrite = 1'b0;
      avsWriteData = 32'h0;
      avsByteEnable = 4'h0;
      inCmd = 16'h0;
      faultCmd = 4'h0;
      error_cnt = 0;
      n_tests = 0;
      repeat (6) @(posedge clock);
      rst_b <= 1'b1;
      chk(fieldOut, 32'h0);
      chk(irq, 32'h0);
      rdchk(`DIO_OFF_DOUT, 32'h0);
      rdchk(`DIO_OFF_WDLOAD, WDT);
      rdchk(`DIO_OFF_STATUS, 32'h0);
      wr(`DIO_OFF_DOUT, 32'h0000_a5c3);
      idle(2);
      chk(fieldOut, 32'ha5c3);
      bus(1'b1, `DIO_OFF_DOUT, 32'h0000_ffff, 4'h1);
      rdchk(`DIO_OFF_DOUT, 32'h0000_a5ff);
      dout = 16'ha5ff;
      rdchk(8'h3c, 32'h0);
      wr(`DIO_OFF_ROUTE, 32'h2);
      idle(2);
      chk(irqRoute, 32'h2);
      // input change events
      setIn(16'h8001);
      rdchk(`DIO_OFF_DIN, 32'h8001);
      wr(`DIO_OFF_ORMASK, 32'h3fff);
      setIn(16'hc001);
      rdchk(`DIO_OFF_STATUS, 32'h0);
      setIn(16'hc009);
      rdchk(`DIO_OFF_STATUS, 32'h1);
      chk(irq, 32'h0);
      wr(`DIO_OFF_MASK, 32'h3ff);
      idle(2);
      chk(irq, 32'h1);
      wr(`DIO_OFF_STATUS, 32'h1);
      idle(2);
      chk(irq, 32'h0);
      // and mode, then both modes at once
      wr(`DIO_OFF_ORMASK, 32'h0);
      setIn(16'h0);
      wr(`DIO_OFF_ANDMASK, 32'h6);
      setIn(16'h6);
      rdchk(`DIO_OFF_STATUS, 32'h2);
      setIn(16'h0);
      wr(`DIO_OFF_ORMASK, 32'h6);
      wr(`DIO_OFF_STATUS, 32'h3ff);
      setIn(16'h6);
      rdchk(`DIO_OFF_STATUS, 32'h1);
      wr(`DIO_OFF_STATUS, 32'h3ff);
      wr(`DIO_OFF_ORMASK, 32'h0);
      // fuse, supply, short, overtemperature
      for (i = 0; i < 4; i++) begin
         @(posedge clock);
         faultCmd <= 4'h1 << i;
         idle(6);
         chk(fieldOut, (i < 2) ? 16'h0 : dout);
         chk(irq, 32'h1);
         rdchk(`DIO_OFF_DIAG, 32'h1 << i);
         rdchk(`DIO_OFF_DOUT, dout);
         @(posedge clock);
         faultCmd <= 4'h0;
         idle(6);
         chk(fieldOut, dout);
         rdchk(`DIO_OFF_STATUS, 32'h1 << (i + 6));
         wr(`DIO_OFF_STATUS, 32'h3ff);
      end
      // watchdog
      wr(`DIO_OFF_WDLOAD, 32'h003f_ffff);
      rdchk(`DIO_OFF_WDLOAD, WDT);
      wr(`DIO_OFF_WDLOAD, 32'h0);
      rdchk(`DIO_OFF_WDLOAD, 32'h1);
      wr(`DIO_OFF_WDLOAD, 32'h3);
      wr(`DIO_OFF_WDCTRL, 32'h1);
      idle(1900);
      chk(fieldOut, dout);
      n = 0;
      while (fieldOut !== 16'h0 && n < 1200) begin
         @(posedge clock);
         n++;
      end
      chk(fieldOut, 32'h0);
      idle(2);
      chk(irq, 32'h1);
      rdchk(`DIO_OFF_STATUS, 32'h4);
      rdchk(`DIO_OFF_DIAG, 32'h10);
      rdchk(`DIO_OFF_DOUT, dout);
      wr(`DIO_OFF_WDKICK, 32'h0);
      idle(3);
      chk(fieldOut, dout);
      wr(`DIO_OFF_WDCTRL, 32'h0);
      wr(`DIO_OFF_STATUS, 32'h3ff);
      // three timers
      wr(`DIO_OFF_TM0, 32'h1);
      wr(`DIO_OFF_TM1, 32'h1);
      wr(`DIO_OFF_TM2, 32'h1);
      wr(`DIO_OFF_TMCTRL, 32'h7);
      n = 0;
      while (irq !== 1'b1 && n < 1100) begin
         @(posedge clock);
         n++;
      end
      idle(3);
      rdchk(`DIO_OFF_STATUS, 32'h38);
      conclude();
   end
endmodule // tb_top
